// >>> stream_bridge_defines.vh
// Constants for the modem stream to network bridge
`ifndef STREAM_BRIDGE_DEFINES_VH
`define STREAM_BRIDGE_DEFINES_VH
`define DATA_PORT 16'h0400
`define CTRL_PORT 16'h0404
`define PING_MAX_BYTES 16'h01d6
`define BUF_BYTES 12'h800
`define BUF_AW 11
`define BUF_CW 12
`define CLK_HZ 50000000
`define OUT_DIV 2'h2
`define PROTO_PING 2'h1
`define PROTO_ARP 2'h2
`define PROTO_TCP 2'h3
`endif

// >>> elastic_ram.v
// Dual-port byte memory for the elastic buffer
`timescale 1ns/1ps
module elastic_ram (
    // Clock
    input wire clk,
    // Write side
    input wire wr_en,
    input wire [10:0] wr_addr,
    input wire [7:0] wr_data,
    // Read side
    input wire [10:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:2047];

    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> stream_bridge.v
// Demodulated bit stream to network byte stream bridge core
// Functional notes
// [RL1] Operator sets IP address over a non-network path before networking.
// [RL2] Network settings latched at power-up; changes apply after next power cycle.
// [RL3] Two listening sockets: port 1024 data, port 1028 control.
// [RL4] Ping, ARP and TCP over IP are the supported protocols.
// [RL5] Echo requests up to 470 bytes are answered.
// [RL6] Echo service runs in parallel without disturbing data transfers.
// [RL7] Only payload bits travel; no headers are forwarded.
// [RL8] A client must connect before it receives demodulated data.
// [RL9] 16 Kbit elastic buffer; data arriving while full is lost.
// [RL10] Client must read at least as fast as the demodulator delivers.
// [RL11] Earliest received bit goes to the byte's most significant bit.
// [RL12] Core runs on one processing clock, unrelated to input clock.
// [RL13] Input connector signals are synchronous to the input reference clock.
// [RL14] Output connector signals follow a derived output clock.
// [RL15] Analog front end runs on an internally generated clock.
// [RL16] Zone crossings pass through a 16 Kbit dual-port elastic buffer.
// [RL17] Outputs change on falling edge; inputs sampled on rising edge. Here all outputs also change on the rising edge of clk.
// [RL18] Sustain 50 Mbit/s average payload over the network link.
// [RL19] Discard demodulated data while no data client is connected.
`timescale 1ns/1ps
`include "stream_bridge_defines.vh"
module stream_bridge (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Power-up network settings
    input wire [31:0] ip_setting,
    input wire setting_strobe,
    output reg [31:0] ip_active,
    output reg net_ready,
    // Demodulated bit stream
    input wire bit_valid,
    input wire bit_data,
    // Network socket events
    input wire [15:0] conn_port,
    input wire conn_open,
    input wire conn_close,
    output reg data_connected,
    output reg ctrl_connected,
    // Payload byte stream toward the data socket
    output reg [7:0] tx_byte,
    output reg tx_valid,
    input wire tx_ready,
    // Echo request and answer
    input wire [1:0] rx_proto,
    input wire rx_start,
    input wire [15:0] rx_len,
    output reg echo_reply,
    output reg arp_reply,
    output reg echo_drop,
    // Status
    output reg overflow,
    output reg [11:0] fill_level,
    output reg out_clk_en
);
    reg [7:0] pack_reg;
    reg [2:0] bit_cnt_reg;
    reg [10:0] wr_ptr_reg;
    reg [10:0] rd_ptr_reg;
    reg [11:0] count_reg;
    reg rd_pend_reg;
    reg cfg_taken_reg;
    reg [1:0] div_reg;
    wire [7:0] ram_q;
    wire [7:0] byte_next;
    wire byte_done;
    wire buf_full;
    wire buf_empty;
    wire do_write;
    wire do_read;
    wire out_free;

    function is_port;
        input [15:0] p;
        input [15:0] want;
        begin
            is_port = (p == want);
        end
    endfunction

    assign byte_next = {pack_reg[6:0], bit_data}; // RL11
    assign byte_done = bit_valid && (bit_cnt_reg == 3'h7);
    assign buf_full = (count_reg == `BUF_BYTES); // RL9
    assign buf_empty = (count_reg == 12'h000);
    assign do_write = byte_done && data_connected && !buf_full; // RL9 RL19
    assign out_free = !tx_valid || tx_ready;
    assign do_read = !buf_empty && !rd_pend_reg && out_free;

    elastic_ram ram_i (
        .clk(clk),
        .wr_en(do_write),
        .wr_addr(wr_ptr_reg),
        .wr_data(byte_next),
        .rd_addr(rd_ptr_reg),
        .rd_data(ram_q)
    ); // RL16

    // Settings taken once after reset
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ip_active <= 32'h00000000;
            cfg_taken_reg <= 1'b0;
            net_ready <= 1'b0;
        end
        else if (setting_strobe && !cfg_taken_reg)
        begin
            ip_active <= ip_setting; // RL2
            cfg_taken_reg <= 1'b1;
            net_ready <= (ip_setting != 32'h00000000); // RL1
        end
    end

    // Listening sockets
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_connected <= 1'b0;
            ctrl_connected <= 1'b0;
        end
        else if (net_ready)
        begin
            if (is_port(conn_port, `DATA_PORT)) // RL3
            begin
                if (conn_open)
                    data_connected <= 1'b1; // RL8
                else if (conn_close)
                    data_connected <= 1'b0;
            end
            if (is_port(conn_port, `CTRL_PORT)) // RL3
            begin
                if (conn_open)
                    ctrl_connected <= 1'b1;
                else if (conn_close)
                    ctrl_connected <= 1'b0;
            end
        end
    end

    // Bit packer, only payload bits enter
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pack_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end
        else if (!data_connected)
        begin
            bit_cnt_reg <= 3'h0; // RL19
        end
        else if (bit_valid)
        begin
            pack_reg <= byte_next; // RL7 RL11 RL13 RL17
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Elastic buffer pointers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= 11'h000;
            rd_ptr_reg <= 11'h000;
            count_reg <= 12'h000;
            rd_pend_reg <= 1'b0;
            overflow <= 1'b0;
            fill_level <= 12'h000;
        end
        else
        begin
            if (do_write)
                wr_ptr_reg <= wr_ptr_reg + 11'h001;
            if (do_read)
                rd_ptr_reg <= rd_ptr_reg + 11'h001;
            rd_pend_reg <= do_read;
            count_reg <= count_reg + {11'h000, do_write} - {11'h000, do_read};
            fill_level <= count_reg;
            if (byte_done && data_connected && buf_full)
                overflow <= 1'b1; // RL9 RL10
            else if (!data_connected)
                overflow <= 1'b0;
        end
    end

    // Output byte register
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
        end
        else if (rd_pend_reg)
        begin
            tx_byte <= ram_q; // RL18
            tx_valid <= 1'b1;
        end
        else if (tx_ready)
        begin
            tx_valid <= 1'b0;
        end
    end

    // Ping and ARP answers, independent of the data path
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            echo_reply <= 1'b0;
            arp_reply <= 1'b0;
            echo_drop <= 1'b0;
        end
        else
        begin
            echo_reply <= net_ready && rx_start && (rx_proto == `PROTO_PING)
                && (rx_len <= `PING_MAX_BYTES); // RL4 RL5 RL6
            echo_drop <= net_ready && rx_start && (rx_proto == `PROTO_PING)
                && (rx_len > `PING_MAX_BYTES); // RL5
            arp_reply <= net_ready && rx_start && (rx_proto == `PROTO_ARP); // RL4
        end
    end

    // Output clock enable divider
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= 2'h0;
            out_clk_en <= 1'b0;
        end
        else
        begin
            div_reg <= (div_reg == `OUT_DIV) ? 2'h0 : div_reg + 2'h1;
            out_clk_en <= (div_reg == `OUT_DIV); // RL12 RL14 RL15
        end
    end
endmodule

// >>> stream_bridge_assertions.sv
// Port checks for the stream bridge
`timescale 1ns/1ps
`include "stream_bridge_defines.vh"
module stream_bridge_assertions (
    // Clock and reset
    input wire clk, rst_n,
    // Settings and sockets
    input wire [31:0] ip_active,
    input wire [15:0] conn_port, rx_len,
    input wire net_ready, conn_open, data_connected, ctrl_connected,
    // Stream
    input wire [7:0] tx_byte,
    input wire tx_valid, tx_ready, overflow, out_clk_en,
    // Echo
    input wire [1:0] rx_proto,
    input wire rx_start, echo_reply, arp_reply, echo_drop
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire ping = rx_start && net_ready && rx_proto == `PROTO_PING;
wire arp = rx_start && net_ready && rx_proto == `PROTO_ARP;
wire opn = net_ready && conn_open;
AST_ECHO: assert property (ping && rx_len <= `PING_MAX_BYTES |=> echo_reply && !echo_drop)
    else $error("echo missing");
AST_DROP: assert property (ping && rx_len > `PING_MAX_BYTES |=> echo_drop && !echo_reply)
    else $error("long echo answered");
AST_ARP: assert property (arp |=> arp_reply && !echo_reply)
    else $error("arp missing");
AST_DATA: assert property (opn && conn_port == `DATA_PORT |=> data_connected)
    else $error("data socket not open");
AST_CTRL: assert property (opn && conn_port == `CTRL_PORT |=> ctrl_connected)
    else $error("control socket not open");
AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte lost while stalled");
AST_IP: assert property (net_ready |=> net_ready && $stable(ip_active))
    else $error("ip changed");
AST_OCLK: assert property (out_clk_en |=> !out_clk_en [*2] ##1 out_clk_en)
    else $error("output clock rate");
AST_IDLE: assert property (!net_ready |-> !data_connected && !ctrl_connected)
    else $error("socket before ip");
COV_ECHO: cover property (echo_reply);
COV_ARP: cover property (arp_reply);
COV_FULL: cover property (overflow);
COV_XFER: cover property (tx_valid && tx_ready);
endmodule
bind stream_bridge stream_bridge_assertions stream_bridge_assertions_i (.clk, .rst_n,
    .ip_active, .conn_port, .rx_len, .net_ready, .conn_open, .data_connected,
    .ctrl_connected, .tx_byte, .tx_valid, .tx_ready, .overflow, .out_clk_en,
    .rx_proto, .rx_start, .echo_reply, .arp_reply, .echo_drop);

// >>> net_client_model.sv
// Network client that drains the payload byte stream
`timescale 1ns/1ps
module net_client_model (
    // Clock
    input wire clk,
    // Byte stream
    input wire [7:0] tx_byte,
    input wire tx_valid,
    output reg tx_ready,
    // Control and record
    input wire stall,
    output reg [15:0] got_count
);
reg [7:0] got [0:3];
initial
begin
    tx_ready = 0;
    got_count = 0;
end
always @(negedge clk) tx_ready <= !stall;
always @(posedge clk)
    if (tx_valid && tx_ready)
    begin
        got[got_count[1:0]] <= tx_byte;
        got_count <= got_count + 16'h1;
    end
endmodule

// >>> modem_stream_to_tcp_bridge_test.sv
// Self-checking bench for the stream bridge
`timescale 1ns/1ps
`include "stream_bridge_defines.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module modem_stream_to_tcp_bridge_test;
reg clk = 0, rst_n = 0, setting_strobe = 0, bit_valid = 0, bit_data = 0;
reg conn_open = 0, conn_close = 0, rx_start = 0, stall = 0;
reg [31:0] ip_setting = 0;
reg [15:0] conn_port = 0, rx_len = 0, n;
reg [1:0] rx_proto = 0;
wire [31:0] ip_active;
wire [7:0] tx_byte;
wire [11:0] fill_level;
wire [15:0] got_count;
wire net_ready, data_connected, ctrl_connected, tx_valid, tx_ready;
wire echo_reply, arp_reply, echo_drop, overflow, out_clk_en;
integer miscompares = 0, checks_done = 0, k;
always #10 clk = ~clk;
stream_bridge stream_bridge_i (.clk, .rst_n, .ip_setting, .setting_strobe, .ip_active,
    .net_ready, .bit_valid, .bit_data, .conn_port, .conn_open, .conn_close,
    .data_connected, .ctrl_connected, .tx_byte, .tx_valid, .tx_ready, .rx_proto,
    .rx_start, .rx_len, .echo_reply, .arp_reply, .echo_drop, .overflow,
    .fill_level, .out_clk_en);
net_client_model net_client_model_i (.clk, .tx_byte, .tx_valid, .tx_ready, .stall,
    .got_count);
task tick; @(negedge clk); endtask
task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
task conn(input [15:0] p, input o);
    conn_port = p; conn_open = o; conn_close = !o; tick;
    conn_open = 0; conn_close = 0; tick;
endtask
task bits(input [15:0] w, input integer c);
    integer i;
    for (i = 15; i > 15 - c; i--)
    begin
        bit_valid = 1; bit_data = w[i]; tick;
    end
endtask
task echo1(input [1:0] p, input [15:0] l, input [2:0] e);
    rx_proto = p; rx_len = l; rx_start = 1; tick; rx_start = 0;
    `CHK({echo_reply, arp_reply, echo_drop}, e)
    tick;
endtask
task setip(input [31:0] v);
    ip_setting = v; setting_strobe = 1; tick; setting_strobe = 0; tick;
endtask
task wait_got(input [15:0] m);
    k = 0;
    while (got_count !== m && k < 100)
    begin
        tick; k++;
    end
endtask
task t_setting;
    conn(`DATA_PORT, 1);
    `CHK(data_connected, 1'b0)
    setip(32'hc0a80a05);
    `CHK(net_ready, 1'b1)
    setip(32'h0a000001);
    `CHK(ip_active, 32'hc0a80a05)
    $display("setting test ends");
endtask
task t_pack;
    conn(`DATA_PORT, 1);
    `CHK(data_connected, 1'b1)
    conn(`CTRL_PORT, 1);
    `CHK(ctrl_connected, 1'b1)
    n = got_count;
    fork
        bits(16'ha53c, 16);
        begin repeat (3) tick; echo1(`PROTO_PING, 16'h0040, 3'h4); end
    join
    bit_valid = 0;
    wait_got(n + 16'h2);
    `CHK(net_client_model_i.got[n[1:0]], 8'ha5)
    `CHK(net_client_model_i.got[n[1:0] + 2'h1], 8'h3c)
    $display("pack test ends");
endtask
task t_echo;
    echo1(`PROTO_PING, `PING_MAX_BYTES, 3'h4);
    echo1(`PROTO_PING, `PING_MAX_BYTES + 16'h1, 3'h1);
    echo1(`PROTO_ARP, 16'h0000, 3'h2);
    echo1(`PROTO_TCP, 16'h0000, 3'h0);
    k = 0;
    repeat (9)
    begin
        tick;
        if (out_clk_en === 1'b1) k++;
    end
    `CHK(k, 3)
    $display("echo test ends");
endtask
task t_discard;
    n = got_count;
    bits(16'hf000, 4); bit_valid = 0;
    conn(`DATA_PORT, 0);
    bits(16'hffff, 16); bit_valid = 0;
    conn(`DATA_PORT, 1);
    bits(16'h5a00, 8); bit_valid = 0;
    wait_got(n + 16'h1); repeat (20) tick;
    `CHK(net_client_model_i.got[n[1:0]], 8'h5a)
    `CHK(got_count, n + 16'h1)
    $display("discard test ends");
endtask
task t_overflow;
    stall = 1;
    repeat (1025) bits(16'hc3c3, 16);
    bit_valid = 0; tick; tick;
    `CHK(overflow, 1'b1)
    `CHK(fill_level, 12'h800)
    stall = 0; k = 0;
    while (fill_level !== 12'h000 && k < 10000)
    begin
        tick; k++;
    end
    `CHK(fill_level, 12'h000)
    $display("overflow test ends");
endtask
initial
begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_of_test;
end
initial
begin
    repeat (12) tick;
    rst_n = 1; tick;
    t_setting; t_pack; t_echo; t_discard; t_overflow;
    end_of_test;
end
endmodule
